/* rtl/maae_pkg.sv */
/*
  constants, state type and timing figures for the monitor average and
  alert engine.
  assumes one 25 MHz clock and a byte-addressed 16-bit register port.
*/
// Contract
// - current from shunt times calibration, zero uncalibrated
// - power from last current and bus
// - per-sample results go to accumulator first
// - load four averages together when count completes
// - arithmetic never lengthens the conversion cycle
// - separate shunt and bus conversion times
// - single alert threshold register at 07h
// - exactly five selectable alert functions
// - open-drain alert asserted on threshold crossing
// - highest set select bit wins
// - conversion ready may also drive alert
// - ready signalling off means limit-only alert
// - shunt over-limit checked every shunt conversion
// - limit flag bit 4 set on violation
// - alert polarity follows bit 1
// - latch holds until config write or select read
// - bus limits checked every bus conversion
// - power limit checked after each bus conversion
// - compare raw samples, not averaged outputs
// - ready flag sets at end, clears on start write/select read
// - mode 111 continuous, 001-011 single shot

package maae_pkg;

  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_SHUNT = 8'h01;
  localparam logic [7:0] ADDR_BUS = 8'h02;
  localparam logic [7:0] ADDR_POWER = 8'h03;
  localparam logic [7:0] ADDR_CURRENT = 8'h04;
  localparam logic [7:0] ADDR_CAL = 8'h05;
  localparam logic [7:0] ADDR_SELECT = 8'h06;
  localparam logic [7:0] ADDR_LIMIT = 8'h07;

  localparam logic [15:0] CONFIG_RESET = 16'h4127;
  localparam logic [15:0] CAL_RESET = 16'h0000;
  localparam logic [15:0] LIMIT_RESET = 16'h0000;

  localparam int CFG_AVG_LSB = 9;
  localparam int CFG_BUSCT_LSB = 6;
  localparam int CFG_SHCT_LSB = 3;
  localparam int CFG_MODE_LSB = 0;

  localparam int SEL_LSB = 11;
  localparam int READY_EN_BIT = 10;
  localparam int LIMIT_FLAG_BIT = 4;
  localparam int DONE_FLAG_BIT = 3;
  localparam int LEVEL_BIT = 1;
  localparam int LATCH_BIT = 0;

  localparam int CLK_MHZ = 25;
  localparam int CT_US [8] = '{140, 204, 332, 588, 1100, 2116, 4156, 8244};
  localparam int AVG_SHIFT [8] = '{0, 2, 4, 6, 7, 8, 9, 10};
  localparam int CURRENT_SHIFT = 11;
  localparam int POWER_DIV = 20000;

  typedef enum logic [1:0] {
    MAAE_IDLE,
    MAAE_SHUNT,
    MAAE_BUS,
    MAAE_FIN
  } maae_state_e;

endpackage

/* rtl/maae_calc.sv */
/*
  current and power arithmetic, one registered step per conversion.
  assumes go strobes are single-cycle and inputs valid with them.
*/
`timescale 1ns/1ps
`default_nettype none

module maae_calc
  import maae_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] cal_i,
  input wire logic [15:0] shunt_i,
  input wire logic shunt_go_i,
  input wire logic [15:0] bus_i,
  input wire logic bus_go_i,
  output logic [15:0] current_o,
  output logic [15:0] power_o,
  output logic power_valid_o
);

  logic signed [32:0] prod_c;
  logic [15:0] mag;
  logic [31:0] prod_p;

  assign prod_c = $signed(shunt_i) * $signed({2'b00, cal_i[14:0]});
  assign mag = current_o[15] ? 16'(-current_o) : current_o;
  assign prod_p = 32'(mag) * 32'(bus_i);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      current_o <= 16'h0000;
    end else if (shunt_go_i) begin
      current_o <= 16'(prod_c >>> CURRENT_SHIFT);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      power_o <= 16'h0000;
      power_valid_o <= 1'b0;
    end else begin
      power_valid_o <= bus_go_i;
      if (bus_go_i) begin
        power_o <= 16'(prod_p / 32'(POWER_DIV));
      end
    end
  end

endmodule

`default_nettype wire

/* rtl/maae_engine.sv */
/*
  conversion sequencer, averaging, output registers and alert logic.
  assumes the adc codes are valid at the end of each conversion slot and
  that the register port gives one-cycle read and write strobes.
*/
`timescale 1ns/1ps
`default_nettype none

module maae_engine
  import maae_pkg::*;
#(
  parameter int CONV_CYC [8] = '{CT_US[0] * CLK_MHZ, CT_US[1] * CLK_MHZ,
    CT_US[2] * CLK_MHZ, CT_US[3] * CLK_MHZ, CT_US[4] * CLK_MHZ,
    CT_US[5] * CLK_MHZ, CT_US[6] * CLK_MHZ, CT_US[7] * CLK_MHZ}
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  input wire logic [15:0] shunt_adc_i,
  input wire logic [15:0] bus_adc_i,
  output logic shunt_busy_o,
  output logic bus_busy_o,
  output logic alert_o,
  output logic alert_oe_o
);

  maae_state_e state, first;
  logic [15:0] cfg, cal, limit, shunt_raw, bus_raw;
  logic [15:0] shunt_out, bus_out, cur_out, pwr_out;
  logic [15:0] calc_current, calc_power;
  logic [4:0] sel;
  logic [2:0] mode;
  logic [3:0] avg_shift;
  logic [10:0] avg_cnt;
  logic [17:0] timer, sh_cyc, bus_cyc;
  logic ready_to_alert_enable, alert_active_level, latch_en;
  logic limit_exceeded_flag, conversion_done_flag, power_valid;
  logic wr_cfg, rd_sel, start, cont, avg_last, shunt_done, bus_done;
  logic cmp_evt, cmp_hit, asserted;
  logic signed [26:0] acc_sh, acc_cur, sum_sh, sum_cur;
  logic [26:0] acc_bus, acc_pwr, sum_bus, sum_pwr;

  assign wr_cfg = reg_wr_i && (reg_addr_i == ADDR_CONFIG);
  assign rd_sel = reg_rd_i && (reg_addr_i == ADDR_SELECT);
  assign start = wr_cfg && (|reg_wdata_i[CFG_MODE_LSB +: 2]);
  assign mode = cfg[CFG_MODE_LSB +: 3];
  assign cont = mode[2];
  assign first = mode[0] ? MAAE_SHUNT : MAAE_BUS;
  assign sh_cyc = 18'(CONV_CYC[cfg[CFG_SHCT_LSB +: 3]]);
  assign bus_cyc = 18'(CONV_CYC[cfg[CFG_BUSCT_LSB +: 3]]);
  assign avg_shift = 4'(AVG_SHIFT[cfg[CFG_AVG_LSB +: 3]]);
  assign avg_last = avg_cnt == 11'((32'd1 << avg_shift) - 32'd1);
  assign shunt_done = (state == MAAE_SHUNT) && (timer == sh_cyc - 18'd1);
  assign bus_done = (state == MAAE_BUS) && (timer == bus_cyc - 18'd1);

  // register writes
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg <= CONFIG_RESET;
      cal <= CAL_RESET;
      limit <= LIMIT_RESET;
      sel <= 5'h00;
      ready_to_alert_enable <= 1'b0;
      alert_active_level <= 1'b0;
      latch_en <= 1'b0;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        ADDR_CONFIG: cfg <= reg_wdata_i;
        ADDR_CAL: cal <= reg_wdata_i;
        ADDR_LIMIT: limit <= reg_wdata_i;
        ADDR_SELECT: begin
          sel <= reg_wdata_i[SEL_LSB +: 5];
          ready_to_alert_enable <= reg_wdata_i[READY_EN_BIT];
          alert_active_level <= reg_wdata_i[LEVEL_BIT];
          latch_en <= reg_wdata_i[LATCH_BIT];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= MAAE_IDLE;
      timer <= 18'h0_0000;
    end else if (wr_cfg) begin
      timer <= 18'h0_0000;
      if (start) begin
        state <= reg_wdata_i[CFG_MODE_LSB] ? MAAE_SHUNT : MAAE_BUS;
      end else begin
        state <= MAAE_IDLE;
      end
    end else begin
      unique case (state)
        MAAE_IDLE: timer <= 18'h0_0000;
        MAAE_SHUNT: begin
          if (shunt_done) begin
            timer <= 18'h0_0000;
            state <= mode[1] ? MAAE_BUS : MAAE_FIN;
          end else begin
            timer <= timer + 18'd1;
          end
        end
        MAAE_BUS: begin
          if (bus_done) begin
            timer <= 18'h0_0000;
            state <= MAAE_FIN;
          end else begin
            timer <= timer + 18'd1;
          end
        end
        MAAE_FIN: begin
          if (avg_last && !cont) begin
            state <= MAAE_IDLE;
          end else begin
            state <= first;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      shunt_busy_o <= 1'b0;
      bus_busy_o <= 1'b0;
    end else begin
      shunt_busy_o <= state == MAAE_SHUNT;
      bus_busy_o <= state == MAAE_BUS;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      shunt_raw <= 16'h0000;
      bus_raw <= 16'h0000;
    end else begin
      if (shunt_done) begin
        shunt_raw <= shunt_adc_i;
      end
      if (bus_done) begin
        bus_raw <= bus_adc_i;
      end
    end
  end

  maae_calc u_calc (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .cal_i(cal),
    .shunt_i(shunt_adc_i),
    .shunt_go_i(shunt_done),
    .bus_i(bus_adc_i),
    .bus_go_i(bus_done),
    .current_o(calc_current),
    .power_o(calc_power),
    .power_valid_o(power_valid)
  );

  assign sum_sh = (avg_cnt == 11'd0 ? 27'sd0 : acc_sh)
    + 27'(signed'(shunt_raw));
  assign sum_cur = (avg_cnt == 11'd0 ? 27'sd0 : acc_cur)
    + 27'(signed'(calc_current));
  assign sum_bus = (avg_cnt == 11'd0 ? 27'd0 : acc_bus) + 27'(bus_raw);
  assign sum_pwr = (avg_cnt == 11'd0 ? 27'd0 : acc_pwr) + 27'(calc_power);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      acc_sh <= 27'sd0;
      acc_cur <= 27'sd0;
      acc_bus <= 27'd0;
      acc_pwr <= 27'd0;
      avg_cnt <= 11'd0;
    end else begin
      if (state == MAAE_FIN) begin
        acc_sh <= sum_sh;
        acc_cur <= sum_cur;
        acc_bus <= sum_bus;
        acc_pwr <= sum_pwr;
      end
      if (start) begin
        avg_cnt <= 11'd0;
      end else if (state == MAAE_FIN) begin
        avg_cnt <= avg_last ? 11'd0 : avg_cnt + 11'd1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      shunt_out <= 16'h0000;
      bus_out <= 16'h0000;
      cur_out <= 16'h0000;
      pwr_out <= 16'h0000;
    end else if ((state == MAAE_FIN) && avg_last) begin
      shunt_out <= 16'(sum_sh >>> avg_shift);
      cur_out <= 16'(sum_cur >>> avg_shift);
      bus_out <= 16'(sum_bus >> avg_shift);
      pwr_out <= 16'(sum_pwr >> avg_shift);
    end
  end

  always_comb begin
    cmp_evt = 1'b0;
    cmp_hit = 1'b0;
    if (sel[4]) begin
      cmp_evt = shunt_done;
      cmp_hit = $signed(shunt_adc_i) > $signed(limit);
    end else if (sel[3]) begin
      cmp_evt = shunt_done;
      cmp_hit = $signed(shunt_adc_i) < $signed(limit);
    end else if (sel[2]) begin
      cmp_evt = bus_done;
      cmp_hit = bus_adc_i > limit;
    end else if (sel[1]) begin
      cmp_evt = bus_done;
      cmp_hit = bus_adc_i < limit;
    end else if (sel[0]) begin
      cmp_evt = power_valid;
      cmp_hit = calc_power > limit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      limit_exceeded_flag <= 1'b0;
    end else if (cmp_evt && cmp_hit) begin
      limit_exceeded_flag <= 1'b1;
    end else if (latch_en ? (wr_cfg || rd_sel) : cmp_evt) begin
      limit_exceeded_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      conversion_done_flag <= 1'b0;
    end else if ((state == MAAE_FIN) && avg_last) begin
      conversion_done_flag <= 1'b1;
    end else if (start || rd_sel) begin
      conversion_done_flag <= 1'b0;
    end
  end

  assign asserted = limit_exceeded_flag
    || (ready_to_alert_enable && conversion_done_flag);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      alert_o <= 1'b0;
      alert_oe_o <= 1'b0;
    end else begin
      alert_o <= 1'b0;
      alert_oe_o <= alert_active_level ? !asserted : asserted;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_CONFIG: reg_rdata_o <= cfg;
        ADDR_SHUNT: reg_rdata_o <= shunt_out;
        ADDR_BUS: reg_rdata_o <= bus_out;
        ADDR_POWER: reg_rdata_o <= pwr_out;
        ADDR_CURRENT: reg_rdata_o <= cur_out;
        ADDR_CAL: reg_rdata_o <= cal;
        ADDR_SELECT: reg_rdata_o <= {sel, ready_to_alert_enable, 5'h00,
          limit_exceeded_flag, conversion_done_flag, 1'b0,
          alert_active_level, latch_en};
        ADDR_LIMIT: reg_rdata_o <= limit;
        default: reg_rdata_o <= 16'h0000;
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_cycle_end;
    (state == MAAE_FIN) && avg_last;
  endsequence

  sequence s_power_sel_bus;
    (sel == 5'b00001) && bus_done;
  endsequence

  a_current_zero_cal: assert property (
    ((cal == 16'h0000) && shunt_done) |=> (calc_current == 16'h0000))
    else $error("current not zero without calibration");
  a_power_from_zero: assert property (
    (bus_done && (calc_current == 16'h0000)) |=> (calc_power == 16'h0000))
    else $error("power not zero with zero current");
  a_single_avg_load: assert property (
    (s_cycle_end and (avg_shift == 4'd0))
      |=> (shunt_out == $past(shunt_raw)) && (bus_out == $past(bus_raw)))
    else $error("single sample not loaded to outputs");
  a_outputs_together: assert property (
    (cur_out != $past(cur_out)) |-> $past(state == MAAE_FIN && avg_last))
    else $error("output changed outside cycle end");
  a_power_no_delay: assert property (
    bus_done |=> power_valid ##1 (state != MAAE_FIN))
    else $error("power result late");
  a_conv_slot_holds: assert property (
    ((state == MAAE_SHUNT) && (timer < sh_cyc - 18'd1) && !wr_cfg)
      |=> (state == MAAE_SHUNT))
    else $error("shunt slot ended early");
  a_shunt_priority: assert property (
    (sel[4] && shunt_done && ($signed(shunt_adc_i) > $signed(limit)))
      |=> limit_exceeded_flag)
    else $error("shunt over-limit missed");
  a_bus_over_flag: assert property (
    ((sel[4:2] == 3'b001) && bus_done && (bus_adc_i > limit))
      |=> limit_exceeded_flag)
    else $error("bus over-limit missed");
  a_power_over_flag: assert property (
    s_power_sel_bus ##1 ((sel == 5'b00001) && (calc_power > limit))
      |=> limit_exceeded_flag)
    else $error("power over-limit missed");
  a_latch_holds: assert property (
    (latch_en && limit_exceeded_flag && !wr_cfg && !rd_sel)
      |=> limit_exceeded_flag)
    else $error("latched flag dropped");
  a_unlatched_drop: assert property (
    (!latch_en && cmp_evt && !cmp_hit) |=> !limit_exceeded_flag)
    else $error("unlatched flag stuck");
  a_ready_sets: assert property (
    s_cycle_end |=> conversion_done_flag)
    else $error("ready flag not set");
  a_ready_alert: assert property (
    (ready_to_alert_enable && conversion_done_flag && !alert_active_level)
      |=> alert_oe_o)
    else $error("ready not shown on alert");
  a_level_drive: assert property (
    (!asserted && !alert_active_level) |=> !alert_oe_o)
    else $error("alert driven while inactive");
  a_single_shot_stop: assert property (
    (s_cycle_end and (!cont && !wr_cfg)) |=> (state == MAAE_IDLE))
    else $error("single shot did not stop");

endmodule

`default_nettype wire

/* test/maae_host_model.sv */
/*
  host model for the register port: strobe writes, reads, cause check.
  assumes the engine takes strobes on the rising edge of clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module maae_host_model
  import maae_pkg::*;
(
  input wire logic clk_i,
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [15:0] reg_wdata_o,
  input wire logic [15:0] reg_rdata_i
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 16'h0000;
  end

  // drop qualifiers to inverse once taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    #1;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
    reg_addr_o = ~a;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    #1;
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    @(posedge clk_i);
    d = reg_rdata_i;
    #1;
  endtask

  task automatic cause(output logic lim, output logic done);
    logic [15:0] d;
    rd(ADDR_SELECT, d);
    lim = d[LIMIT_FLAG_BIT];
    done = d[DONE_FLAG_BIT];
  endtask
endmodule

`default_nettype wire

/* test/monitor_average_alert_engine_tb_top.sv */
/*
  testbench for the monitor average and alert engine.
  assumes the host model on the register port; adc codes held per cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module monitor_average_alert_engine_tb_top;
  import maae_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] shunt_adc = 16'h1F40;
  logic [15:0] bus_adc = 16'h2570;
  logic [15:0] rdata, wdata, sel;
  logic [7:0] addr;
  logic wr, rd, shunt_busy, bus_busy, alert, alert_oe, lim, done;
  logic sh_q = 1'b0;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int sh_cnt = 0;
  int bu_cnt = 0;
  int starts = 0;
  logic [15:0] t_sel [7] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000,
    16'h0800, 16'hC000, 16'h2800};
  logic [15:0] t_lim [7] = '{16'h1F3F, 16'h1F40, 16'h2570, 16'h2571,
    16'h12B7, 16'h2000, 16'h2000};
  logic t_exp [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  wire alert_pin = alert_oe ? alert : 1'b1;

  always #20 clk = ~clk;

  maae_engine #(.CONV_CYC('{8, 10, 12, 14, 16, 18, 20, 22})) u_dut (
    .clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .shunt_adc_i(shunt_adc), .bus_adc_i(bus_adc),
    .shunt_busy_o(shunt_busy), .bus_busy_o(bus_busy), .alert_o(alert),
    .alert_oe_o(alert_oe));

  maae_host_model u_host (
    .clk_i(clk), .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata));

  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(string nm, logic [15:0] got, logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rchk(string nm, logic [7:0] a, logic [15:0] exp);
    logic [15:0] d;
    u_host.rd(a, d);
    check(nm, d, exp);
  endtask

  // wait for one full shunt and bus cycle to finish
  task automatic conv_wait();
    int n = 0;
    while (bus_busy !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    while (bus_busy !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) begin
      error_cnt++;
      complete_run();
    end
    repeat (4) @(posedge clk);
    #1;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    sh_cnt <= sh_cnt + int'(shunt_busy);
    bu_cnt <= bu_cnt + int'(bus_busy);
    starts <= starts + int'(shunt_busy & ~sh_q);
    sh_q <= shunt_busy;
    if (cyc == 10000) begin
      error_cnt++;
      complete_run();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rchk("config", ADDR_CONFIG, CONFIG_RESET);
    rchk("cal", ADDR_CAL, CAL_RESET);
    rchk("select", ADDR_SELECT, 16'h0000);
    rchk("unmapped", 8'h08, 16'h0000);
    u_host.wr(ADDR_LIMIT, 16'hA5C3);
    rchk("limit", ADDR_LIMIT, 16'hA5C3);
    u_host.wr(ADDR_CURRENT, 16'h1234);
    rchk("current ro", ADDR_CURRENT, 16'h0000);
    sh_cnt = 0;
    bu_cnt = 0;
    u_host.wr(ADDR_CONFIG, 16'h00CB);
    conv_wait();
    check("shunt slot", 16'(sh_cnt), 16'd10);
    check("bus slot", 16'(bu_cnt), 16'd14);
    rchk("current uncal", ADDR_CURRENT, 16'h0000);
    rchk("power uncal", ADDR_POWER, 16'h0000);
    rchk("shunt", ADDR_SHUNT, 16'h1F40);
    rchk("bus", ADDR_BUS, 16'h2570);
    starts = 0;
    repeat (60) @(posedge clk);
    check("single shot", 16'(starts), 16'd0);
    u_host.wr(ADDR_CAL, 16'h0A00);
    u_host.wr(ADDR_CONFIG, 16'h0003);
    conv_wait();
    rchk("current", ADDR_CURRENT, 16'h2710);
    rchk("power", ADDR_POWER, 16'h12B8);
    shunt_adc = 16'h0800;
    bus_adc = 16'h1000;
    u_host.wr(ADDR_CONFIG, 16'h0203);
    conv_wait();
    rchk("current held", ADDR_CURRENT, 16'h2710);
    rchk("shunt held", ADDR_SHUNT, 16'h1F40);
    repeat (3) conv_wait();
    rchk("avg shunt", ADDR_SHUNT, 16'h0800);
    rchk("avg bus", ADDR_BUS, 16'h1000);
    rchk("avg current", ADDR_CURRENT, 16'h0A00);
    rchk("avg power", ADDR_POWER, 16'h020C);
    shunt_adc = 16'h1F40;
    bus_adc = 16'h2570;
    for (int i = 0; i < 7; i++) begin
      sel = t_sel[i] | {14'h0, i[0], 1'b0};
      u_host.wr(ADDR_SELECT, sel);
      u_host.wr(ADDR_LIMIT, t_lim[i]);
      u_host.wr(ADDR_CONFIG, 16'h0003);
      conv_wait();
      check("alert pin", {15'h0, alert_pin},
        {15'h0, t_exp[i] ^ ~i[0]});
      rchk("flags", ADDR_SELECT, sel | {11'h0, t_exp[i], 4'h8});
    end
    u_host.wr(ADDR_SELECT, 16'h8001);
    u_host.wr(ADDR_LIMIT, 16'h1F3F);
    u_host.wr(ADDR_CONFIG, 16'h0007);
    conv_wait();
    shunt_adc = 16'h0000;
    conv_wait();
    check("latched pin", 16'(alert_pin), 16'h0000);
    rchk("latched flag", ADDR_SELECT, 16'h8019);
    conv_wait();
    check("released pin", 16'(alert_pin), 16'h0001);
    rchk("cleared flag", ADDR_SELECT, 16'h8009);
    u_host.wr(ADDR_CONFIG, 16'h0000);
    u_host.wr(ADDR_SELECT, 16'h0400);
    u_host.wr(ADDR_CONFIG, 16'h0003);
    conv_wait();
    check("ready pin", 16'(alert_pin), 16'h0000);
    u_host.wr(ADDR_CONFIG, 16'h0000);
    repeat (3) @(posedge clk);
    check("ready kept", 16'(alert_pin), 16'h0000);
    u_host.cause(lim, done);
    check("cause", 16'({lim, done}), 16'h0001);
    repeat (3) @(posedge clk);
    check("ready read", 16'(alert_pin), 16'h0001);
    u_host.wr(ADDR_CONFIG, 16'h0003);
    conv_wait();
    u_host.wr(ADDR_CONFIG, 16'h0003);
    repeat (3) @(posedge clk);
    check("ready write", 16'(alert_pin), 16'h0001);
    complete_run();
  end
endmodule

`default_nettype wire
